// [rtl/fsss_cfg.svh]
`ifndef FSSS_CFG_SVH
`define FSSS_CFG_SVH
// open-loop ramp base length in switching periods
`define FSSS_RAMP_BASE 775
// current-limit code width and full-scale code (full sense limit)
`define FSSS_LIM_W 8
`define FSSS_LIM_FULL 8'h_ff
// handover window in limit codes (about 100 mV of 120 mV scale)
`define FSSS_MATCH_WIN 8'h_d5
// handover limit in switching periods
`define FSSS_HANDOVER_MAX 128
// rectifier stop limit in switching periods
`define FSSS_SR_STOP_PER 2
// alignment timeout in microseconds
`define FSSS_ALIGN_US 1500
`define FSSS_CLK_MHZ 100
`define FSSS_ALIGN_CYC (`FSSS_ALIGN_US * `FSSS_CLK_MHZ)
// soft start current multiplier while tracking
`define FSSS_TRACK_GAIN 10
`endif

// [rtl/fsss_pkg.sv]
package fsss_pkg;
  typedef enum logic [2:0] {
    FSSS_IDLE, FSSS_OL_RAMP, FSSS_ALIGN, FSSS_HANDOVER,
    FSSS_CL_RAMP, FSSS_REGULATE, FSSS_SOFT_STOP
  } fsss_state_t;
  typedef enum logic [1:0] {FSSS_RAMP_X4, FSSS_RAMP_X16, FSSS_RAMP_X64, FSSS_RAMP_X256} fsss_ramp_t;
endpackage : fsss_pkg

// [rtl/fsss_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface fsss_if;
  logic period_tick;
  logic clr;
  logic [15:0] period_count;
  modport owner(output clr, output period_tick, input period_count);
  modport counter(input period_tick, input clr, output period_count);
endinterface : fsss_if
`default_nettype wire

// [rtl/fsss_period_counter.sv]
`timescale 1ns/1ns
`default_nettype none
// counts switching periods since the last clear; saturates
module fsss_period_counter (
  input wire logic clk,
  input wire logic rst,
  fsss_if.counter cnt
);
  logic [15:0] count;
  logic [15:0] next_count;
  // ======================================
  // counter
  always_comb begin
    next_count = count;
    if (cnt.clr) begin
      next_count = 16'h_0000;
    end else if (cnt.period_tick && count != 16'h_ffff) begin
      next_count = count + 16'h_0001;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 16'h_0000;
    end else begin
      count <= next_count;
    end
  end
  assign cnt.period_count = count;
endmodule : fsss_period_counter
`default_nettype wire

// [rtl/fsss_sequencer.sv]
//
// Operation
// - external-start variant starts on supply and enable
// - internal-regulator variant waits for bias done
// - hysteresis current only while enable low
// - enable loss: soft stop, rectifier off fast
// - open-loop limit steps up one code per ramp_len/255 periods
// - resistor code picks ramp length
// - secondary lockout: soft start tracks feedback
// - align compensation to limit, with timeout
// - sampled compensation ends primary gate pulses
// - handover on match or 128 periods
// - closed-loop ramp to regulation then upper level
// - rectifier pulses only after secondary lockout
// - precharged secondary skips open-loop ramp
// - rectifier held until soft start reaches feedback or regulation starts
// - feedback stuck: stay open loop or track
// - feedback at reference forces secondary control
// - secondary starts at its lockout threshold
`timescale 1ns/1ns
`default_nettype none
`include "fsss_cfg.svh"
module fsss_sequencer import fsss_pkg::*; #(
  parameter bit INTERNAL_REG = 1'b0,
  parameter int ALIGN_CYCLES = `FSSS_ALIGN_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic input_supply_ok,
  input wire logic enable_above,
  input wire logic primary_regulator_output_ok,
  input wire logic secondary_supply_ok,
  input wire logic period_start,
  input wire logic [1:0] ramp_select,
  input wire logic feedback_at_ref,
  input wire logic ss_at_upper,
  input wire logic ss_reached_feedback,
  input wire logic feedback_tracks,
  input wire logic comp_aligned,
  input wire logic [7:0] comp_level,
  input wire logic current_at_limit,
  output logic enable_hyst_on,
  output logic [7:0] primary_limit,
  output logic gate_drive,
  output logic ss_track_fast,
  output logic ss_charge,
  output logic comp_align,
  output logic secondary_control,
  output logic rectifier_drive_one,
  output logic rectifier_drive_two,
  output fsss_state_t state_out
);
  // ======================================
  // pin synchronisers
  logic [7:0] s1;
  logic [7:0] s2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= 8'h_00;
      s2 <= 8'h_00;
    end else begin
      s1 <= {input_supply_ok, enable_above, primary_regulator_output_ok, secondary_supply_ok,
             period_start, feedback_at_ref, ss_reached_feedback, feedback_tracks};
      s2 <= s1;
    end
  end
  logic vin_ok, en_ok, bias_ok, sec_ok, per_lvl, fb_ref, ss_fb, fb_trk;
  assign {vin_ok, en_ok, bias_ok, sec_ok, per_lvl, fb_ref, ss_fb, fb_trk} = s2;
  logic [4:0] t1;
  logic [4:0] t2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      t1 <= 5'h_00;
      t2 <= 5'h_00;
    end else begin
      t1 <= {ss_at_upper, comp_aligned, current_at_limit, ramp_select};
      t2 <= t1;
    end
  end
  logic ss_up, comp_ok, cur_lim;
  logic [1:0] rsel;
  assign {ss_up, comp_ok, cur_lim, rsel} = t2;

  // ======================================
  // period edge and counter
  logic per_q;
  logic tick;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      per_q <= 1'b0;
    end else begin
      per_q <= per_lvl;
    end
  end
  assign tick = per_lvl && !per_q;
  fsss_if pif();
  assign pif.period_tick = tick;
  fsss_period_counter u_cnt (
    .clk(clk),
    .rst(rst),
    .cnt(pif.counter)
  );

  // ramp length per step: base times 4,16,64,256 over full-scale steps
  function automatic logic [17:0] ramp_len(input logic [1:0] code);
    case (code)
      2'd0: ramp_len = 18'(4 * `FSSS_RAMP_BASE);
      2'd1: ramp_len = 18'(16 * `FSSS_RAMP_BASE);
      2'd2: ramp_len = 18'(64 * `FSSS_RAMP_BASE);
      default: ramp_len = 18'(256 * `FSSS_RAMP_BASE);
    endcase
  endfunction : ramp_len

  // ======================================
  // sequencer state
  fsss_state_t state, next_state;
  logic [1:0] ramp_code, next_ramp_code;
  logic [7:0] limit, next_limit;
  logic [17:0] acc, next_acc;
  logic [17:0] atimer, next_atimer;
  logic sec_seen, next_sec_seen;
  logic sr_ok, next_sr_ok;
  logic [1:0] stop_cnt, next_stop_cnt;
  logic start_ok;
  logic [7:0] diff;
  // variant gate: internal regulator must have charged
  assign start_ok = vin_ok && en_ok && (!INTERNAL_REG || bias_ok);
  assign diff = (comp_level > limit) ? comp_level - limit : limit - comp_level;

  // next-state logic; accumulator spreads full-scale rise over the ramp
  always_comb begin
    next_state = state;
    next_ramp_code = ramp_code;
    next_limit = limit;
    next_acc = acc;
    next_atimer = atimer;
    next_sec_seen = sec_seen;
    next_sr_ok = sr_ok;
    next_stop_cnt = stop_cnt;
    pif.clr = 1'b0;
    case (state)
      FSSS_IDLE: begin
        next_ramp_code = rsel;
        next_limit = 8'h_00;
        next_acc = 18'h_0_0000;
        next_sr_ok = 1'b0;
        next_sec_seen = 1'b0;
        if (start_ok) begin
          if (sec_ok) begin
            next_state = FSSS_CL_RAMP;
            next_sec_seen = 1'b1;
          end else begin
            next_state = FSSS_OL_RAMP;
          end
        end
      end
      FSSS_OL_RAMP: begin
        if (tick && limit != `FSSS_LIM_FULL) begin
          // accumulate every period; step on overflow, 255 codes over the chosen length
          if (acc + 18'(`FSSS_LIM_FULL) >= ramp_len(ramp_code)) begin
            next_acc = acc + 18'(`FSSS_LIM_FULL) - ramp_len(ramp_code);
            next_limit = limit + 8'h_01;
          end else begin
            next_acc = acc + 18'(`FSSS_LIM_FULL);
          end
        end
        // stuck feedback keeps open loop until secondary comes up
        if (sec_ok) begin
          next_state = FSSS_ALIGN;
          next_atimer = 18'h_0_0000;
          next_sec_seen = 1'b1;
        end
        if (fb_ref) begin
          next_state = FSSS_CL_RAMP;
        end
      end
      FSSS_ALIGN: begin
        next_atimer = atimer + 18'h_0_0001;
        if (comp_ok || atimer >= 18'(ALIGN_CYCLES - 1)) begin
          next_state = FSSS_HANDOVER;
          pif.clr = 1'b1;
        end
        if (fb_ref) begin
          next_state = FSSS_CL_RAMP;
        end
      end
      FSSS_HANDOVER: begin
        if (diff <= `FSSS_MATCH_WIN ||
            pif.period_count >= 16'(`FSSS_HANDOVER_MAX) || fb_ref) begin
          next_state = FSSS_CL_RAMP;
        end
      end
      FSSS_CL_RAMP: begin
        if (ss_fb) begin
          next_sr_ok = 1'b1;
        end
        if (sec_ok) begin
          next_sec_seen = 1'b1;
        end
        if (ss_up && fb_ref) begin
          next_state = FSSS_REGULATE;
        end
      end
      FSSS_REGULATE: begin
        next_sr_ok = 1'b1;
      end
      FSSS_SOFT_STOP: begin
        if (tick && stop_cnt != 2'(`FSSS_SR_STOP_PER)) begin
          next_stop_cnt = stop_cnt + 2'd1;
        end
        next_limit = 8'h_00;
        // stop always completes; a re-enable restarts from idle, never hangs here
        if (stop_cnt == 2'(`FSSS_SR_STOP_PER)) begin
          next_state = FSSS_IDLE;
        end
      end
      default: next_state = FSSS_IDLE;
    endcase
    // enable loss from any running state
    if (!en_ok && state != FSSS_IDLE && state != FSSS_SOFT_STOP) begin
      next_state = FSSS_SOFT_STOP;
      next_stop_cnt = 2'd0;
      next_sr_ok = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= FSSS_IDLE;
      ramp_code <= 2'd0;
      limit <= 8'h_00;
      acc <= 18'h_0_0000;
      atimer <= 18'h_0_0000;
      sec_seen <= 1'b0;
      sr_ok <= 1'b0;
      stop_cnt <= 2'd0;
    end else begin
      state <= next_state;
      ramp_code <= next_ramp_code;
      limit <= next_limit;
      acc <= next_acc;
      atimer <= next_atimer;
      sec_seen <= next_sec_seen;
      sr_ok <= next_sr_ok;
      stop_cnt <= next_stop_cnt;
    end
  end

  // ======================================
  // outputs from flip-flops
  logic gate_q, sr_q, trk_q, chg_q, algn_q, secq_q;
  logic [7:0] lim_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_q <= 1'b0;
      sr_q <= 1'b0;
      trk_q <= 1'b0;
      chg_q <= 1'b0;
      algn_q <= 1'b0;
      secq_q <= 1'b0;
      lim_q <= 8'h_00;
    end else begin
      // gate ends when sensed current reaches the active limit
      gate_q <= per_lvl && !cur_lim && state inside {FSSS_OL_RAMP, FSSS_ALIGN,
                FSSS_HANDOVER, FSSS_CL_RAMP, FSSS_REGULATE};
      sr_q <= sr_ok && sec_ok && en_ok && !per_lvl;
      trk_q <= (state == FSSS_ALIGN) ||
               (state == FSSS_CL_RAMP && sec_seen && !ss_fb && fb_trk);
      chg_q <= state inside {FSSS_CL_RAMP, FSSS_REGULATE};
      algn_q <= state == FSSS_ALIGN;
      secq_q <= state inside {FSSS_HANDOVER, FSSS_CL_RAMP, FSSS_REGULATE};
      // received level sets the limit once the secondary holds control
      lim_q <= (state inside {FSSS_HANDOVER, FSSS_CL_RAMP, FSSS_REGULATE})
               ? comp_level : limit;
    end
  end
  assign primary_limit = lim_q;
  assign enable_hyst_on = !en_ok;
  assign gate_drive = gate_q;
  assign rectifier_drive_one = sr_q;
  assign rectifier_drive_two = sr_q;
  assign ss_track_fast = trk_q;
  assign ss_charge = chg_q;
  assign comp_align = algn_q;
  assign secondary_control = secq_q;
  assign state_out = state;

  // ======================================
  // checks
  property p_stop;
    @(posedge clk) disable iff (rst) $fell(en_ok) &&
      !(state inside {FSSS_IDLE, FSSS_SOFT_STOP}) |=> state == FSSS_SOFT_STOP;
  endproperty
  a_stop: assert property (p_stop) else $error("no soft stop on enable loss");
  property p_sr_sec;
    @(posedge clk) disable iff (rst) rectifier_drive_one |-> $past(sec_ok) && $past(sr_ok);
  endproperty
  a_sr_sec: assert property (p_sr_sec) else $error("rectifier without secondary");
  property p_sr_off;
    @(posedge clk) disable iff (rst) !en_ok |=> !rectifier_drive_one;
  endproperty
  a_sr_off: assert property (p_sr_off) else $error("rectifier kept after enable loss");
  property p_hyst;
    @(posedge clk) disable iff (rst) !$past(rst, 2) |->
      enable_hyst_on == !$past(enable_above, 2);
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis current wrong");
  property p_skip;
    @(posedge clk) disable iff (rst) state == FSSS_IDLE && start_ok && sec_ok |=> state == FSSS_CL_RAMP;
  endproperty
  a_skip: assert property (p_skip) else $error("precharged start used open loop");
  property p_fbref;
    @(posedge clk) disable iff (rst) state == FSSS_OL_RAMP && fb_ref && en_ok |=> state == FSSS_CL_RAMP;
  endproperty
  a_fbref: assert property (p_fbref) else $error("no handover at reference");
  property p_ho;
    @(posedge clk) disable iff (rst) state == FSSS_HANDOVER && en_ok &&
      pif.period_count >= 16'd128 |=> state == FSSS_CL_RAMP;
  endproperty
  a_ho: assert property (p_ho) else $error("handover limit missed");
  property p_ramp;
    @(posedge clk) disable iff (rst) state == FSSS_OL_RAMP && !tick |=> limit == $past(limit);
  endproperty
  a_ramp: assert property (p_ramp) else $error("limit moved off a period");
endmodule : fsss_sequencer
`default_nettype wire

// [tb/fsss_stage_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========
// power stage model: oscillator, sensed current, compensation
module fsss_stage_model #(
  parameter int PER = 8,
  parameter logic [7:0] COMP = 8'h_80
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic gate_drive,
  input wire logic [7:0] primary_limit,
  output logic period_start,
  output logic [7:0] comp_level,
  output logic current_at_limit
);
  logic [7:0] ph;
  // free-running phase; a real oscillator never pauses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph <= 8'h_00;
    end else begin
      ph <= (ph == 8'(PER - 1)) ? 8'h_00 : ph + 8'h_01;
    end
  end
  // gate window is the first half of each period
  assign period_start = ph < 8'(PER / 2);
  // sensed current ramps only while the gate is on
  assign current_at_limit = gate_drive && ((ph << 6) >= primary_limit);
  assign comp_level = COMP;
endmodule : fsss_stage_model
`default_nettype wire

// [tb/flyback_soft_start_sequencer_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module flyback_soft_start_sequencer_tb import fsss_pkg::*;;
  logic clk, rst, input_supply_ok, enable_above, primary_regulator_output_ok;
  logic secondary_supply_ok, feedback_at_ref, ss_at_upper, ss_reached_feedback;
  logic feedback_tracks, comp_aligned, period_start, current_at_limit;
  logic enable_hyst_on, gate_drive, ss_track_fast, ss_charge, comp_align;
  logic secondary_control, rectifier_drive_one, rectifier_drive_two, seen;
  logic [1:0] ramp_select;
  logic [7:0] comp_level, primary_limit, lim;
  fsss_state_t state_out;
  int errors, n_tests;
  // ==========
  // design and stage model
  fsss_sequencer #(.INTERNAL_REG(1'b0), .ALIGN_CYCLES(20)) i_fsss_sequencer (
    .clk, .rst, .input_supply_ok, .enable_above, .primary_regulator_output_ok,
    .secondary_supply_ok, .period_start, .ramp_select, .feedback_at_ref,
    .ss_at_upper, .ss_reached_feedback, .feedback_tracks, .comp_aligned,
    .comp_level, .current_at_limit, .enable_hyst_on, .primary_limit,
    .gate_drive, .ss_track_fast, .ss_charge, .comp_align, .secondary_control,
    .rectifier_drive_one, .rectifier_drive_two, .state_out
  );
  fsss_stage_model i_fsss_stage_model (
    .clk, .rst, .gate_drive, .primary_limit, .period_start, .comp_level,
    .current_at_limit
  );
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========
  // helpers; stimulus moves on falling edges only
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // bounded wait; a miss ends the run
  task automatic wait_st(input fsss_state_t s, input int n);
    for (int i = 0; i < n && state_out !== s; i++) cyc(1);
    chk(8'(state_out), 8'(s));
    if (state_out !== s) final_report();
  endtask : wait_st
  task automatic sr_seen(input int n, output logic s);
    s = 1'b0;
    repeat (n) begin
      cyc(1);
      s = s | rectifier_drive_one | rectifier_drive_two;
    end
  endtask : sr_seen
  task automatic gate_seen(input int n, output logic s);
    s = 1'b0;
    repeat (n) begin
      cyc(1);
      s = s | gate_drive;
    end
  endtask : gate_seen
  // ==========
  // scenarios
  task automatic t_reset;
    cyc(3);
    chk(8'(state_out), 8'(FSSS_IDLE));
    chk(primary_limit, 8'h_00);
    chk(8'({rectifier_drive_one, rectifier_drive_two}), 8'h_00);
    chk(8'(enable_hyst_on), 8'h_01);
  endtask : t_reset
  task automatic t_startup;
    input_supply_ok = 1'b1;
    enable_above = 1'b1;
    wait_st(FSSS_OL_RAMP, 6);
    cyc(3);
    chk(8'(enable_hyst_on), 8'h_00);
    gate_seen(16, seen);
    chk(8'(seen), 8'h_01);
    // ramp step is about a dozen periods at the shortest speed
    sr_seen(300, seen);
    chk(8'(seen), 8'h_00);
    lim = primary_limit;
    chk(8'(lim != 8'h_00), 8'h_01);
    cyc(300);
    chk(8'(primary_limit > lim), 8'h_01);
    secondary_supply_ok = 1'b1;
    wait_st(FSSS_ALIGN, 6);
    cyc(2);
    chk(8'(comp_align), 8'h_01);
    chk(8'(ss_track_fast), 8'h_01);
    comp_aligned = 1'b1;
    wait_st(FSSS_HANDOVER, 30);
    wait_st(FSSS_CL_RAMP, 1034);
    cyc(2);
    chk(8'(ss_charge), 8'h_01);
    chk(8'(secondary_control), 8'h_01);
    chk(primary_limit, 8'h_80);
    feedback_at_ref = 1'b1;
    ss_at_upper = 1'b1;
    wait_st(FSSS_REGULATE, 6);
    sr_seen(24, seen);
    chk(8'(seen), 8'h_01);
  endtask : t_startup
  task automatic t_stop;
    enable_above = 1'b0;
    wait_st(FSSS_SOFT_STOP, 6);
    gate_seen(16, seen);
    chk(8'(seen), 8'h_00);
    chk(8'({rectifier_drive_one, rectifier_drive_two}), 8'h_00);
    chk(8'(enable_hyst_on), 8'h_01);
    wait_st(FSSS_IDLE, 40);
  endtask : t_stop
  // secondary already above lockout: output precharged
  task automatic t_precharge;
    feedback_at_ref = 1'b0;
    ss_at_upper = 1'b0;
    comp_aligned = 1'b0;
    ss_reached_feedback = 1'b0;
    cyc(4);
    enable_above = 1'b1;
    wait_st(FSSS_CL_RAMP, 6);
    cyc(2);
    chk(8'(secondary_control), 8'h_01);
    sr_seen(24, seen);
    chk(8'(seen), 8'h_00);
    ss_reached_feedback = 1'b1;
    sr_seen(24, seen);
    chk(8'(seen), 8'h_01);
  endtask : t_precharge
  // second ramp code: 16 x 775 periods over 255 steps, one step per ~48.6 periods
  task automatic t_slow_ramp;
    enable_above = 1'b0;
    secondary_supply_ok = 1'b0;
    ramp_select = 2'h_1;
    wait_st(FSSS_IDLE, 40);
    cyc(4);
    enable_above = 1'b1;
    wait_st(FSSS_OL_RAMP, 6);
    cyc(300);
    chk(primary_limit, 8'h_00);
    cyc(200);
    chk(primary_limit, 8'h_01);
  endtask : t_slow_ramp
  // ==========
  // main sequence
  initial begin
    errors = 0;
    n_tests = 0;
    rst = 1'b1;
    {input_supply_ok, enable_above, secondary_supply_ok, feedback_at_ref} = 4'h_0;
    {ss_at_upper, ss_reached_feedback, comp_aligned} = 3'h_0;
    primary_regulator_output_ok = 1'b1;
    feedback_tracks = 1'b1;
    ramp_select = 2'h_0;
    cyc(4);
    rst = 1'b0;
    t_reset();
    t_startup();
    t_stop();
    t_precharge();
    t_slow_ramp();
    final_report();
  end
endmodule : flyback_soft_start_sequencer_tb
`default_nettype wire
